/* File: hdl/sfs_pkg.sv */
package sfs_pkg;
  // Feedback source codes
  typedef enum logic [2:0] {
    SFS_SRC_ARM = 3'h0,
    SFS_SRC_TACHO = 3'h1,
    SFS_SRC_ENC = 3'h2,
    SFS_SRC_ENC_ARM = 3'h3,
    SFS_SRC_ENC_TACHO = 3'h4
  } sfs_src_t;

  // Encoder input formats
  typedef enum logic [1:0] {
    SFS_FMT_PULSE = 2'h0,
    SFS_FMT_PULSE_DIR = 2'h1,
    SFS_FMT_QUAD = 2'h2
  } sfs_fmt_t;

  // Register byte offsets
  localparam logic [7:0] SFS_OFF_CTRL = 8'h00;
  localparam logic [7:0] SFS_OFF_ARM_FS = 8'h04;
  localparam logic [7:0] SFS_OFF_TACHO_FS = 8'h08;
  localparam logic [7:0] SFS_OFF_RPM_FS = 8'h0c;
  localparam logic [7:0] SFS_OFF_LINES = 8'h10;
  localparam logic [7:0] SFS_OFF_STATUS = 8'h14;
  localparam logic [7:0] SFS_OFF_MASK = 8'h18;
  localparam logic [7:0] SFS_OFF_ENC_RATE = 8'h1c;
  localparam logic [7:0] SFS_OFF_SPEED = 8'h20;
  localparam logic [7:0] SFS_OFF_STATE = 8'h24;

  // Control field positions
  localparam int SFS_CTRL_SRC_LSB = 0;
  localparam int SFS_CTRL_FMT_LSB = 4;
  localparam int SFS_CTRL_INV_BIT = 8;
  localparam int SFS_CTRL_LOCK_BIT = 9;
  localparam int SFS_CTRL_FAIL_EN_BIT = 10;
  localparam int SFS_CTRL_FAIL_TRIP_BIT = 11;

  // Status bits
  localparam int SFS_ST_ENC_FAIL = 0;
  localparam int SFS_ST_TACHO_FAIL = 1;
  localparam int SFS_ST_FALLBACK = 2;
  localparam int SFS_ST_DIR_CHANGE = 3;

  // Reset values
  localparam logic [31:0] SFS_RST_CTRL = 32'h0000_0000;
  localparam logic [15:0] SFS_RST_ARM_FS = 16'h0000;
  localparam logic [15:0] SFS_RST_TACHO_FS = 16'h1770;
  localparam logic [15:0] SFS_RST_RPM_FS = 16'h05dc;
  localparam logic [15:0] SFS_RST_LINES = 16'h03e8;

  // Timing: encoder rate gate window
  localparam int SFS_CLK_HZ = 20000000;
  localparam int SFS_GATE_MS = 10;
  localparam int SFS_GATE_CYC = SFS_CLK_HZ / 1000 * SFS_GATE_MS;
endpackage

/* File: hdl/sfs_enc_decode.sv */
`timescale 1ns/1ps
module sfs_enc_decode
  import sfs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Raw encoder pins
  input wire logic encoder_pulse_input,
  input wire logic encoder_direction_input,
  // Setup
  input wire sfs_fmt_t fmt,
  input wire logic sign_invert,
  // Decoded count event
  output logic count_pulse,
  output logic count_fwd
);
  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic last_a;
    logic last_b;
    logic pulse;
    logic fwd;
  } sfs_dec_t;

  sfs_dec_t st;
  sfs_dec_t next_st;
  logic a;
  logic b;
  logic rise_a;
  logic raw_fwd;

  always_comb begin
    next_st = st;
    next_st.sync_a = {st.sync_a[0], encoder_pulse_input};
    next_st.sync_b = {st.sync_b[0], encoder_direction_input};
    a = st.sync_a[1];
    b = st.sync_b[1];
    next_st.last_a = a;
    next_st.last_b = b;
    rise_a = a && !st.last_a;
    raw_fwd = 1'b1;
    next_st.pulse = 1'b0;
    unique case (fmt)
      SFS_FMT_PULSE: begin
        next_st.pulse = rise_a;
      end
      SFS_FMT_PULSE_DIR: begin
        next_st.pulse = rise_a;
        raw_fwd = b;
      end
      SFS_FMT_QUAD: begin
        // One count per A cycle; B low at A rise means A leads B
        next_st.pulse = rise_a;
        raw_fwd = !b;
      end
      default: begin
        next_st.pulse = 1'b0;
      end
    endcase
    if (rise_a) begin
      next_st.fwd = raw_fwd ^ sign_invert;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
      st.fwd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign count_pulse = st.pulse;
  assign count_fwd = st.fwd;
endmodule

/* File: hdl/sfs_rate_meter.sv */
`timescale 1ns/1ps
module sfs_rate_meter
  import sfs_pkg::*;
#(
  parameter int GATE_CYC = SFS_GATE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Count events
  input wire logic count_pulse,
  // Result: pulses per gate window, updated once per window
  output logic [15:0] rate,
  output logic window_done
);
  typedef struct packed {
    logic [23:0] timer;
    logic [15:0] acc;
    logic [15:0] rate;
    logic done;
  } sfs_rate_t;

  sfs_rate_t st;
  sfs_rate_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (count_pulse && st.acc != 16'hffff) begin
      next_st.acc = st.acc + 16'h0001;
    end
    if (st.timer == 24'(GATE_CYC - 1)) begin
      next_st.timer = '0;
      next_st.rate = next_st.acc; // reads zero with no pulses
      next_st.acc = '0;
      next_st.done = 1'b1;
    end else begin
      next_st.timer = st.timer + 24'h000001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rate = st.rate;
  assign window_done = st.done;
endmodule

/* File: hdl/sfs_top.sv */
// What this block does
// - Feedback source select takes codes 0 to 4; armature voltage is default.
// - Code 0 scales armature voltage so full-scale setting equals 100 percent.
// - Code 1 scales tacho voltage so tacho full-scale equals 100 percent.
// - Pulse-with-direction: direction low means reverse, high means forward.
// - Quadrature: direction decoded from phase of the two trains.
// - Accept pulse only, pulse with direction, or quadrature formats.
// - Encoder rate at 100 percent equals the full-speed rpm setting.
// - Code 3: armature voltage is dynamic feedback, encoder trims steady state.
// - Code 4: tacho is dynamic feedback, encoder trims steady state.
// - Codes 3/4 single-line: sign from analogue, direction pin freed unless lock.
// - Encoder/tacho failure either trips or falls back to armature voltage.
// - Encoder speed monitor is always live, whatever source is selected.
// - First train leading second is forward; second leading first is reverse.
// - Encoder polarity setting inverts decoded sign.
// - Encoder speed scaled by configured lines per revolution.
`timescale 1ns/1ps
module sfs_top
  import sfs_pkg::*;
#(
  parameter int GATE_CYC = SFS_GATE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Encoder pins
  input wire logic encoder_pulse_input,
  input wire logic encoder_direction_input,
  // Analogue feedback samples, signed
  input wire logic signed [15:0] armature_voltage_feedback,
  input wire logic signed [15:0] tacho_feedback,
  // Failure detectors
  input wire logic encoder_fail_in,
  input wire logic tacho_fail_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Results
  output logic signed [15:0] speed_feedback,
  output logic signed [15:0] speed_trim,
  output logic signed [15:0] motor_speed_monitor,
  output logic digital_input_three,
  output logic drive_trip,
  output logic irq
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] arm_fs;
    logic [15:0] tacho_fs;
    logic [15:0] rpm_fs;
    logic [15:0] lines;
    logic [3:0] status;
    logic [3:0] mask;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic fallback;
    logic trip;
    logic last_fwd;
    logic dir_free_sync0;
    logic dir_free_sync1;
    logic signed [15:0] fbk;
    logic signed [15:0] trim;
    logic signed [15:0] mon;
  } sfs_top_st_t;

  sfs_top_st_t st;
  sfs_top_st_t next_st;

  logic count_pulse;
  logic count_fwd;
  logic [15:0] enc_rate;
  sfs_src_t src;
  sfs_fmt_t fmt;
  logic do_write;
  logic do_read;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;
  logic signed [31:0] enc_pct;
  logic signed [15:0] enc_signed;
  logic signed [15:0] ana_sel;
  logic signed [31:0] ana_pct;
  logic [3:0] events;
  logic single_line;

  ////////////////////////////////////////////////////////////////////
  sfs_enc_decode u_dec (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .encoder_pulse_input(encoder_pulse_input),
    .encoder_direction_input(encoder_direction_input),
    .fmt(fmt),
    .sign_invert(st.ctrl[SFS_CTRL_INV_BIT]),
    .count_pulse(count_pulse),
    .count_fwd(count_fwd)
  );

  sfs_rate_meter #(.GATE_CYC(GATE_CYC)) u_rate (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .count_pulse(count_pulse),
    .rate(enc_rate),
    .window_done()
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    // Illegal codes fall back to armature voltage
    src = (st.ctrl[2:0] > 3'h4) ? SFS_SRC_ARM : sfs_src_t'(st.ctrl[2:0]);
    fmt = (st.ctrl[5:4] == 2'h3) ? SFS_FMT_QUAD : sfs_fmt_t'(st.ctrl[5:4]);
    if (st.fallback) begin
      src = SFS_SRC_ARM;
    end
    single_line = (fmt != SFS_FMT_QUAD);
  end

  always_comb begin
    // Rate per window scaled to percent of full speed (1 LSB = 0.01 %):
    // rpm = rate * 60 s * windows_per_s / lines
    enc_pct = 32'sd0;
    if (st.lines != 16'h0000 && st.rpm_fs != 16'h0000) begin
      enc_pct = 32'(({16'h0000, enc_rate} * 32'd6000 * 32'(1000 / SFS_GATE_MS))
        / ({16'h0000, st.lines} * {16'h0000, st.rpm_fs} / 32'd100));
    end
    enc_signed = count_fwd ? enc_pct[15:0] : -enc_pct[15:0];
    ana_sel = (src == SFS_SRC_TACHO || src == SFS_SRC_ENC_TACHO) ? tacho_feedback
      : armature_voltage_feedback;
    ana_pct = 32'sd0;
    if (src == SFS_SRC_TACHO || src == SFS_SRC_ENC_TACHO) begin
      if (st.tacho_fs != 16'h0000) begin
        ana_pct = (32'(ana_sel) * 32'sd10000) / 32'($signed({1'b0, st.tacho_fs}));
      end
    end else if (st.arm_fs != 16'h0000) begin
      ana_pct = (32'(ana_sel) * 32'sd10000) / 32'($signed({1'b0, st.arm_fs}));
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    do_write = st.aw_held && st.w_held && !st.bvalid;
    do_read = s_axi_arvalid && !st.rvalid;
    wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      SFS_OFF_CTRL: rd_val = st.ctrl;
      SFS_OFF_ARM_FS: rd_val = {16'h0000, st.arm_fs};
      SFS_OFF_TACHO_FS: rd_val = {16'h0000, st.tacho_fs};
      SFS_OFF_RPM_FS: rd_val = {16'h0000, st.rpm_fs};
      SFS_OFF_LINES: rd_val = {16'h0000, st.lines};
      SFS_OFF_STATUS: rd_val = {28'h0000000, st.status};
      SFS_OFF_MASK: rd_val = {28'h0000000, st.mask};
      SFS_OFF_ENC_RATE: rd_val = {16'h0000, enc_rate};
      SFS_OFF_SPEED: rd_val = {st.mon, st.fbk};
      SFS_OFF_STATE: rd_val = {28'h0000000, st.trip, st.fallback, st.last_fwd, src == 3'h0};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
    wr_ok = st.aw_addr <= SFS_OFF_MASK && st.aw_addr[1:0] == 2'h0;
  end

  always_comb begin
    next_st = st;
    events = 4'h0;
    // Write channel capture, either order
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_ok ? 2'h0 : 2'h2;
      unique case (st.aw_addr)
        SFS_OFF_CTRL: next_st.ctrl = (st.ctrl & ~wmask) | (st.w_data & wmask);
        SFS_OFF_ARM_FS: next_st.arm_fs = (st.arm_fs & ~wmask[15:0])
          | (st.w_data[15:0] & wmask[15:0]);
        SFS_OFF_TACHO_FS: next_st.tacho_fs = (st.tacho_fs & ~wmask[15:0])
          | (st.w_data[15:0] & wmask[15:0]);
        SFS_OFF_RPM_FS: next_st.rpm_fs = (st.rpm_fs & ~wmask[15:0])
          | (st.w_data[15:0] & wmask[15:0]);
        SFS_OFF_LINES: next_st.lines = (st.lines & ~wmask[15:0]) | (st.w_data[15:0] & wmask[15:0]);
        SFS_OFF_STATUS: next_st.status = st.status & ~(st.w_data[3:0] & wmask[3:0]);
        SFS_OFF_MASK: next_st.mask = (st.mask & ~wmask[3:0]) | (st.w_data[3:0] & wmask[3:0]);
        default: next_st.bresp = 2'h2;
      endcase
      if (st.aw_addr == SFS_OFF_CTRL && wmask[8] && !st.w_data[SFS_CTRL_FAIL_EN_BIT]) begin
        // Disabling detection releases a latched fallback or trip
        next_st.fallback = 1'b0;
        next_st.trip = 1'b0;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_read) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      next_st.rresp = rd_ok ? 2'h0 : 2'h2;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Failure handling: encoder only matters where the encoder is used
    if (st.ctrl[SFS_CTRL_FAIL_EN_BIT]) begin
      if ((encoder_fail_in && src >= SFS_SRC_ENC)
          || (tacho_fail_in && (src == SFS_SRC_TACHO || src == SFS_SRC_ENC_TACHO))) begin
        if (st.ctrl[SFS_CTRL_FAIL_TRIP_BIT]) begin
          next_st.trip = 1'b1;
        end else begin
          next_st.fallback = 1'b1;
          events[SFS_ST_FALLBACK] = !st.fallback;
        end
      end
    end
    events[SFS_ST_ENC_FAIL] = encoder_fail_in;
    events[SFS_ST_TACHO_FAIL] = tacho_fail_in;
    if (count_pulse) begin
      next_st.last_fwd = count_fwd;
      events[SFS_ST_DIR_CHANGE] = count_fwd != st.last_fwd;
    end
    // Set wins over a same-cycle clear
    next_st.status = next_st.status | events;

    // Speed outputs are registered every clock cycle
    next_st.mon = enc_signed;
    next_st.trim = 16'sh0000;
    unique case (src)
      SFS_SRC_ARM, SFS_SRC_TACHO: begin
        next_st.fbk = ana_pct[15:0];
      end
      SFS_SRC_ENC: begin
        next_st.fbk = enc_signed;
      end
      SFS_SRC_ENC_ARM, SFS_SRC_ENC_TACHO: begin
        next_st.fbk = ana_pct[15:0];
        if (single_line && !st.ctrl[SFS_CTRL_LOCK_BIT]) begin
          // Magnitude from encoder, sign from analogue feedback
          next_st.trim = (ana_pct < 0) ? -enc_pct[15:0] - ana_pct[15:0]
            : enc_pct[15:0] - ana_pct[15:0];
        end else begin
          next_st.trim = enc_signed - ana_pct[15:0];
        end
      end
      default: begin
        next_st.fbk = ana_pct[15:0];
      end
    endcase
    next_st.dir_free_sync0 = encoder_direction_input;
    next_st.dir_free_sync1 = st.dir_free_sync0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
      st.ctrl <= SFS_RST_CTRL;
      st.arm_fs <= SFS_RST_ARM_FS;
      st.tacho_fs <= SFS_RST_TACHO_FS;
      st.rpm_fs <= SFS_RST_RPM_FS;
      st.lines <= SFS_RST_LINES;
      st.last_fwd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready = !st.w_held;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign speed_feedback = st.fbk;
  assign speed_trim = st.trim;
  assign motor_speed_monitor = st.mon;
  // Direction pin freed for general use; zero while the encoder needs it
  assign digital_input_three = (src >= SFS_SRC_ENC_ARM && single_line
    && !st.ctrl[SFS_CTRL_LOCK_BIT]) ? st.dir_free_sync1 : 1'b0;
  assign drive_trip = st.trip;
  assign irq = |(st.status & st.mask);
endmodule

/* File: verif/sfs_enc_model.sv */
`timescale 1ns/1ps
module sfs_enc_model #(
  parameter int PER = 200
) (
  // Control
  input wire logic mclk,
  input wire logic run,
  input wire logic quad,
  input wire logic fwd,
  // Encoder lines
  output logic pulse,
  output logic dir
);
  // 200 cycles at 20 MHz is 100 kHz, the fastest the encoder may run
  int ph = 0;
  always @(posedge mclk) begin
    ph <= (run && ph < PER - 1) ? ph + 1 : 0;
  end
  assign pulse = run && ph < PER / 2;
  // Forward: second train lags by a quarter period; reverse: it leads
  assign dir = !quad ? fwd : !run ? 1'b0 : fwd ? (ph >= PER / 4 && ph < 3 * PER / 4) :
    (ph >= 3 * PER / 4 || ph < PER / 4);
endmodule

/* File: verif/sfs_top_assertions.sv */
`timescale 1ns/1ps
module sfs_chk #(
  parameter int GATE_CYC = 2000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic encoder_pulse_input,
  input wire logic encoder_direction_input,
  input wire logic encoder_fail_in,
  input wire logic tacho_fail_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic signed [15:0] speed_feedback,
  input wire logic signed [15:0] motor_speed_monitor,
  input wire logic digital_input_three,
  input wire logic drive_trip,
  input wire logic irq
);
  // Two full windows without a pulse edge leave nothing to count
  localparam int REST = 2 * GATE_CYC + 20;
  int quiet;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge mclk) begin
    if (sys_rst || $changed(encoder_pulse_input)) begin
      quiet <= 0;
    end else if (quiet < REST) begin
      quiet <= quiet + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  reset_idle_a:
    assert property ($fell(sys_rst) |-> !irq && !drive_trip && !s_axi_rvalid &&
      !s_axi_bvalid && speed_feedback == 16'sh0) else $error("Not idle after reset");
  trip_cause_a:
    assert property ($rose(drive_trip) |-> $past(encoder_fail_in) || $past(tacho_fail_in) ||
      $past(encoder_fail_in, 2) || $past(tacho_fail_in, 2)) else $error("Trip without fault");
  trip_latch_a:
    assert property (drive_trip && s_axi_wready && !s_axi_wvalid |=> drive_trip)
    else $error("Trip dropped without write");
  freed_pin_a:
    assert property (digital_input_three |-> $past(encoder_direction_input, 2) ||
      $past(encoder_direction_input, 3)) else $error("Freed input not from pin");
  rest_zero_a:
    assert property (quiet == REST |-> motor_speed_monitor == 16'sh0)
    else $error("Monitor not zero at rest");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##[1:2] s_axi_bvalid) else $error("Write answer late");
  read_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("Read taken while busy");
  cover property ($rose(drive_trip));
  cover property ($rose(irq));
  cover property ($rose(digital_input_three));
endmodule

bind sfs_top sfs_chk #(.GATE_CYC(GATE_CYC)) chk (.mclk, .sys_rst, .encoder_pulse_input,
  .encoder_direction_input, .encoder_fail_in, .tacho_fail_in, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .speed_feedback, .motor_speed_monitor, .digital_input_three, .drive_trip, .irq);

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench import sfs_pkg::*; ;
  localparam int GATE = 5000;
  localparam int PER = 200;
  // Pulses per window, scaled with 1000 lines and 150 rpm full speed
  localparam int EXP = GATE / PER * 600000 / (1000 * 150 / 100);
  logic mclk = 1'b0, sys_rst = 1'b1, encoder_fail_in = 1'b0, tacho_fail_in = 1'b0;
  logic signed [15:0] armature_voltage_feedback = 16'h0, tacho_feedback = 16'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, e_run = 1'b0, e_quad = 1'b0, e_fwd = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic encoder_pulse_input, encoder_direction_input, digital_input_three, drive_trip, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic signed [15:0] speed_feedback, speed_trim, motor_speed_monitor, m;
  int n, fails = 0, compares = 0, cyc = 0;
  // Address and value after reset
  logic [39:0] rt[8] = '{40'h00_0000_0000, 40'h04_0000_0000, 40'h08_0000_1770,
    40'h0c_0000_05dc, 40'h10_0000_03e8, 40'h14_0000_0000, 40'h18_0000_0000, 40'h28_0000_0000};
  // Control, armature, tacho, expected feedback
  logic [63:0] ft[6] = '{64'h0000_03e8_0000_2710, 64'h0000_fe0c_0000_ec78,
    64'h0001_0000_0bb8_1388, 64'h0003_00fa_0000_09c4, 64'h0004_0000_e890_d8f0,
    64'h0007_03e8_0000_2710};
  // Control, pin level, freed input
  logic [13:0] dt[6] = '{{12'h013, 2'b11}, {12'h013, 2'b00}, {12'h014, 2'b11},
    {12'h213, 2'b10}, {12'h010, 2'b10}, {12'h023, 2'b10}};
  // Control, quadrature, forward, positive result
  logic [14:0] et[4] = '{{12'h000, 3'b001}, {12'h010, 3'b000}, {12'h020, 3'b111},
    {12'h120, 3'b101}};

  sfs_top #(.GATE_CYC(GATE)) dut (.mclk, .sys_rst, .encoder_pulse_input,
    .encoder_direction_input, .armature_voltage_feedback, .tacho_feedback, .encoder_fail_in,
    .tacho_fail_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .speed_feedback, .speed_trim, .motor_speed_monitor, .digital_input_three, .drive_trip,
    .irq);
  sfs_enc_model #(.PER(PER)) enc (.mclk, .run(e_run), .quad(e_quad), .fwd(e_fwd),
    .pulse(encoder_pulse_input), .dir(encoder_direction_input));

  always #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // The longest path is six idle or running stretches of two windows each
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rt[i]) begin
      rd(rt[i][39:32], d, rs);
      `CHK("reset value", rt[i][31:0], d)
      `CHK("read response", (rt[i][39:32] == 8'h28) ? 2'h2 : 2'h0, rs)
    end
    wr(SFS_OFF_ENC_RATE, 32'h1, rs);
    `CHK("write response", 2'h2, rs)
    wr(SFS_OFF_ARM_FS, 32'h3e8, rs);
    wr(SFS_OFF_RPM_FS, 32'h96, rs);
    foreach (ft[i]) begin
      wr(SFS_OFF_CTRL, {16'h0, ft[i][63:48]}, rs);
      armature_voltage_feedback <= ft[i][47:32];
      tacho_feedback <= ft[i][31:16];
      for (n = 0; n < 20 && speed_feedback !== ft[i][15:0]; n++) @(posedge mclk);
      `CHK("speed_feedback", ft[i][15:0], speed_feedback)
    end
    // Tacho failure with fallback chosen, event masked at first
    armature_voltage_feedback <= 16'h03e8;
    tacho_feedback <= 16'h0bb8;
    wr(SFS_OFF_STATUS, 32'hf, rs);
    wr(SFS_OFF_CTRL, 32'h401, rs);
    tacho_fail_in <= 1'b1;
    repeat (3) @(posedge mclk);
    tacho_fail_in <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("fallback feedback", 16'h2710, speed_feedback)
    `CHK("masked irq", 1'b0, irq)
    rd(SFS_OFF_STATUS, d, rs);
    `CHK("status", 2'b11, d[2:1])
    wr(SFS_OFF_MASK, 32'h2, rs);
    repeat (2) @(posedge mclk);
    `CHK("irq", 1'b1, irq)
    wr(SFS_OFF_STATUS, 32'h6, rs);
    repeat (2) @(posedge mclk);
    `CHK("cleared irq", 1'b0, irq)
    wr(SFS_OFF_CTRL, 32'h0, rs);
    // Encoder failure trips the drive while the encoder is the selected source
    wr(SFS_OFF_CTRL, 32'hc02, rs);
    encoder_fail_in <= 1'b1;
    repeat (3) @(posedge mclk);
    encoder_fail_in <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("drive_trip", 1'b1, drive_trip)
    wr(SFS_OFF_CTRL, 32'h0, rs);
    repeat (2) @(posedge mclk);
    `CHK("trip released", 1'b0, drive_trip)
    foreach (dt[i]) begin
      wr(SFS_OFF_CTRL, {20'h0, dt[i][13:2]}, rs);
      e_fwd <= dt[i][1];
      repeat (6) @(posedge mclk);
      `CHK("digital_input_three", dt[i][0], digital_input_three)
    end
    // Source stays armature voltage: the monitor must still follow the encoder
    foreach (et[i]) begin
      wr(SFS_OFF_CTRL, {20'h0, et[i][14:3]}, rs);
      e_quad <= et[i][2];
      e_fwd <= et[i][1];
      e_run <= 1'b1;
      repeat (2 * GATE + 60) @(posedge mclk);
      m = et[i][0] ? motor_speed_monitor : -motor_speed_monitor;
      `CHK("monitor", 1'b1, m > EXP * 9 / 10 && m < EXP * 11 / 10)
      e_run <= 1'b0;
    end
    // Encoder alone, then as trim beside armature feedback of opposite sign
    armature_voltage_feedback <= 16'hfe0c;
    e_quad <= 1'b0;
    e_fwd <= 1'b1;
    wr(SFS_OFF_CTRL, 32'h12, rs);
    e_run <= 1'b1;
    repeat (2 * GATE + 60) @(posedge mclk);
    `CHK("encoder feedback", EXP, speed_feedback)
    wr(SFS_OFF_CTRL, 32'h13, rs);
    repeat (4) @(posedge mclk);
    `CHK("combined feedback", -5000, speed_feedback)
    `CHK("signed trim", 5000 - EXP, speed_trim)
    wr(SFS_OFF_CTRL, 32'h213, rs);
    repeat (4) @(posedge mclk);
    `CHK("locked trim", 5000 + EXP, speed_trim)
    e_run <= 1'b0;
    rd(SFS_OFF_STATUS, d, rs);
    `CHK("sticky events", 2'b11, {d[3], d[0]})
    repeat (2 * GATE + 60) @(posedge mclk);
    `CHK("idle monitor", 16'h0, motor_speed_monitor)
    summarize();
  end
endmodule
